/* File: rtl/arw_writer.sv */
`timescale 1ns/10ps
// What this block does
// RQ1: Trailer holds transfer status and timestamp
// RQ2: Timestamp is seconds low three, full count
// RQ3: Stamp from cycle start, else local timer
// RQ4: Data error backs out the packet
// RQ5: Bus reset inserts marker in request stream
// RQ6: Marker header carries PHY transaction code
// RQ7: Marker carries new topology generation
// RQ8: Marker carries bus-reset event code
// RQ9: Marker undefined byte free, stamp at creation
// RQ10: Marker waits until receive space frees; the code waits only for an idle writer with no write open, not for space
// RQ11: Reset event raised at once
// RQ12: PHY packets only while acceptance enabled
// RQ13: PHY inverse quadlet stored as received
// RQ14: Two quadlets failing CRC are PHY packets
// RQ15: Packet event per delivered packet
// RQ16: Buffer-done event when interrupt field is 11
// RQ17: First header quadlet stored with its fields
// RQ18: Reserved header bits stored unchanged
// RQ19: Block length and extended code stored
// RQ20: First data byte in high byte
// RQ21: Sender pads data to whole quadlets
// RQ22: Order is header, data, trailer
// RQ23: Residual count updated after good packet
// RQ24: CRC quadlets never stored
module arw_writer
  import arw_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic [31:0] RX_DATA_I,
  input wire logic RX_VALID_I,
  input wire logic RX_LAST_I,
  input wire logic RX_CRC_I,
  input wire logic RX_CRC_BAD_I,
  input wire logic RX_DATA_ERR_I,
  output logic RX_READY_O,
  input wire logic BUS_RESET_I,
  input wire logic [7:0] TOPOLOGY_GENERATION_I,
  input wire logic ACCEPT_PHY_PACKETS_I,
  input wire logic [15:0] CONTEXT_CONTROL_REQ_I,
  input wire logic [15:0] CONTEXT_CONTROL_RSP_I,
  input wire logic CYCLE_START_I,
  input wire logic [31:0] CYCLE_START_TIME_I,
  input wire logic CYCLE_MASTER_PRESENT_I,
  input wire logic [31:0] CYCLE_TIME_REG_I,
  input wire logic [1:0] BUF_LOAD_I,
  input wire logic [31:0] BUF_ADDR_I,
  input wire logic [15:0] BUF_SIZE_I,
  input wire logic [1:0] BUF_INT_I,
  input wire logic MEM_READY_I,
  output logic MEM_WE_O,
  output logic [31:0] MEM_ADDR_O,
  output logic [31:0] MEM_DATA_O,
  output logic DESC_UPDATE_O,
  output logic DESC_CTX_O,
  output logic [15:0] DESC_RESIDUAL_O,
  output logic [15:0] DESC_STATUS_O,
  output logic RESET_SEEN_EVENT_O,
  output logic REQUEST_PACKET_EVENT_O,
  output logic RESPONSE_PACKET_EVENT_O,
  output logic REQUEST_BUFFER_DONE_EVENT_O,
  output logic RESPONSE_BUFFER_DONE_EVENT_O
);
  arw_state_e state; // Writer sequence state
  arw_state_e next_state; // Sequence state for the next cycle
  logic ctx; // Context of the packet in progress
  logic next_ctx; // Context chosen this cycle
  logic [31:0] q0; // First held quadlet
  logic [31:0] q1; // Second held quadlet
  logic is_phy; // Packet in progress is a PHY packet
  logic is_marker; // Packet in progress is the bus-reset marker
  logic [31:0] ptr [NUM_CTX]; // Write address per context
  logic [15:0] res [NUM_CTX]; // Residual byte count per context
  logic [1:0] int_sel [NUM_CTX]; // Descriptor interrupt field
  logic [31:0] saved_ptr; // Pointer before the packet began
  logic [15:0] saved_res; // Residual before the packet began
  logic [15:0] stamp; // Live timestamp
  logic [15:0] pkt_stamp; // Timestamp caught during the packet
  logic [15:0] br_stamp; // Timestamp caught at bus reset
  logic [7:0] br_gen; // Generation caught at bus reset
  logic br_rise; // Synchronised bus-reset edge
  logic br_pending; // Marker still owed to the request stream
  logic accept; // Receive quadlet taken this cycle
  logic issue; // Memory write launched this cycle
  logic [31:0] issue_word; // Word for that write
  logic pkt_start; // Pointer snapshot point
  logic backout; // Packet discarded after writes began
  logic finish; // Packet fully written
  logic next_we; // Memory strobe for the next cycle
  logic [15:0] sel_res; // Residual of the chosen context
  logic [15:0] xfer_status; // Status half of the trailer

  // The reset pin comes from outside the core clock domain
  arw_sync u_sync (
    .clk_i(CORE_CLK_I),
    .rstn_i(RSTN_I),
    .async_i(BUS_RESET_I),
    .rise_o(br_rise)
  );

  // Cycle time source picks cycle start or the local timer
  arw_stamp u_stamp (
    .clk_i(CORE_CLK_I),
    .rstn_i(RSTN_I),
    .cycle_start_i(CYCLE_START_I),
    .cycle_start_time_i(CYCLE_START_TIME_I),
    .master_present_i(CYCLE_MASTER_PRESENT_I),
    .cycle_time_reg_i(CYCLE_TIME_REG_I),
    .stamp_o(stamp)
  );

  // Responses are recognised by their transaction code
  function automatic logic is_rsp(input logic [3:0] tc);
    is_rsp = (tc == TCODE_WR_RSP) || (tc == TCODE_RDQ_RSP) ||
             (tc == TCODE_RDB_RSP) || (tc == TCODE_LOCK_RSP);
  endfunction

  assign accept = RX_VALID_I & RX_READY_O;
  assign sel_res = res[next_ctx];
  assign next_we = issue | (MEM_WE_O & ~MEM_READY_I);
  // Low sixteen bits of the owning context's control register
  assign xfer_status = ctx ? CONTEXT_CONTROL_RSP_I : CONTEXT_CONTROL_REQ_I; // [RQ1]

  // Sequence: one memory write outstanding at a time
  always_comb begin
    next_state = state;
    next_ctx = ctx;
    issue = 1'b0;
    issue_word = 32'h0000_0000;
    pkt_start = 1'b0;
    backout = 1'b0;
    finish = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (accept) begin
          // A lone quadlet is no packet at all
          if (!RX_LAST_I) begin
            next_state = ST_HOLD;
          end
        end else if (br_pending && !MEM_WE_O) begin
          // Marker goes to the request stream only between packets
          next_ctx = CTX_REQ; // [RQ5] [RQ10]
          pkt_start = 1'b1;
          issue = 1'b1;
          issue_word = {24'h00_0000, TCODE_PHY, 4'h0}; // [RQ6]
          next_state = ST_MARK;
        end
      end
      ST_HOLD: begin
        if (accept) begin
          if (RX_LAST_I) begin
            // Two quadlets with a bad CRC are a PHY packet
            if (RX_CRC_BAD_I && ACCEPT_PHY_PACKETS_I) begin // [RQ14] [RQ12]
              next_ctx = CTX_REQ;
              pkt_start = 1'b1;
              issue = 1'b1;
              issue_word = {24'h00_0000, TCODE_PHY, 4'h0};
              next_state = ST_PHY0;
            end else begin
              next_state = ST_IDLE; // [RQ12]
            end
          end else begin
            // Header word goes out untouched, reserved bits included
            next_ctx = is_rsp(q0[TCODE_LSB +: 4]);
            pkt_start = 1'b1;
            issue = 1'b1;
            issue_word = q0; // [RQ17] [RQ18] [RQ22]
            next_state = ST_FLUSH;
          end
        end
      end
      ST_PHY0: begin
        if (!MEM_WE_O) begin
          issue = 1'b1;
          issue_word = q0;
          next_state = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        if (!MEM_WE_O) begin
          // For a PHY packet this is the inverse quadlet, unchecked
          issue = 1'b1;
          issue_word = q1; // [RQ13]
          next_state = is_phy ? ST_TRAIL : ST_STREAM;
        end
      end
      ST_STREAM: begin
        if (accept) begin
          if (RX_LAST_I && RX_DATA_ERR_I) begin
            // Discard the tail and restore the pointers
            backout = 1'b1; // [RQ4]
            next_state = ST_IDLE;
          end else begin
            // Header, length word and padded data pass as received
            issue = ~RX_CRC_I; // [RQ24] [RQ19] [RQ20] [RQ21]
            issue_word = RX_DATA_I;
            if (RX_LAST_I) begin
              next_state = ST_TRAIL; // [RQ22]
            end
          end
        end
      end
      ST_MARK: begin
        if (!MEM_WE_O) begin
          issue = 1'b1;
          issue_word = {MARK_UNDEF, br_gen, 16'h0000}; // [RQ7] [RQ9]
          next_state = ST_TRAIL;
        end
      end
      ST_TRAIL: begin
        if (!MEM_WE_O) begin
          issue = 1'b1;
          if (is_marker) begin
            issue_word = {11'h000, EVT_BUS_RESET, br_stamp}; // [RQ8] [RQ9]
          end else begin
            issue_word = {xfer_status, pkt_stamp}; // [RQ1] [RQ22]
          end
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!MEM_WE_O) begin
          finish = 1'b1;
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // State, context and the receive handshake
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state <= ST_IDLE;
      ctx <= CTX_REQ;
      RX_READY_O <= 1'b0;
    end else begin
      state <= next_state;
      ctx <= next_ctx;
      // Stall the link while a write is open or space runs short
      RX_READY_O <= ~next_we &&
        ((next_state == ST_IDLE && !br_pending && !br_rise) ||
         next_state == ST_HOLD ||
         (next_state == ST_STREAM && sel_res >= MIN_SPACE));
    end
  end

  // Held quadlets, packet kind and the in-packet timestamp
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      q0 <= 32'h0000_0000;
      q1 <= 32'h0000_0000;
      is_phy <= 1'b0;
      is_marker <= 1'b0;
      pkt_stamp <= 16'h0000;
    end else begin
      if (accept && state == ST_IDLE) begin
        q0 <= RX_DATA_I;
        pkt_stamp <= stamp; // [RQ2] [RQ3]
      end
      if (accept && state == ST_HOLD) begin
        q1 <= RX_DATA_I;
      end
      if (pkt_start) begin
        is_phy <= (state == ST_HOLD) && RX_LAST_I; // [RQ14]
        is_marker <= (state == ST_IDLE);
      end
    end
  end

  // Marker bookkeeping; a new reset wins over the clear
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      br_pending <= 1'b0;
      br_stamp <= 16'h0000;
      br_gen <= 8'h00;
    end else begin
      if (br_rise) begin
        br_pending <= 1'b1; // [RQ10]
        br_stamp <= stamp; // [RQ9]
        br_gen <= TOPOLOGY_GENERATION_I; // [RQ7]
      end else if (pkt_start && state == ST_IDLE) begin
        br_pending <= 1'b0;
      end
    end
  end

  // Per-context buffer pointers, residuals and snapshot for backout
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int c = 0; c < NUM_CTX; c++) begin
        ptr[c] <= 32'h0000_0000;
        res[c] <= 16'h0000;
        int_sel[c] <= 2'b00;
      end
      saved_ptr <= 32'h0000_0000;
      saved_res <= 16'h0000;
    end else begin
      if (pkt_start) begin
        saved_ptr <= ptr[next_ctx];
        saved_res <= res[next_ctx];
      end
      for (int c = 0; c < NUM_CTX; c++) begin
        if (BUF_LOAD_I[c]) begin
          ptr[c] <= BUF_ADDR_I;
          res[c] <= BUF_SIZE_I;
          int_sel[c] <= BUF_INT_I;
        end else if (backout && ctx == c[0]) begin
          ptr[c] <= saved_ptr; // [RQ4]
          res[c] <= saved_res; // [RQ4]
        end else if (issue && next_ctx == c[0]) begin
          // CRC quadlets never issue, so never advance this
          ptr[c] <= ptr[c] + ADDR_STEP; // [RQ24]
          res[c] <= res[c] - QUAD_BYTES;
        end
      end
    end
  end

  // Memory write port; a write stands until the memory takes it
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      MEM_WE_O <= 1'b0;
      MEM_ADDR_O <= 32'h0000_0000;
      MEM_DATA_O <= 32'h0000_0000;
    end else if (issue) begin
      MEM_WE_O <= 1'b1;
      MEM_ADDR_O <= ptr[next_ctx];
      MEM_DATA_O <= issue_word;
    end else if (MEM_READY_I) begin
      MEM_WE_O <= 1'b0;
    end
  end

  // Descriptor update only for a packet written without error
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      DESC_UPDATE_O <= 1'b0;
      DESC_CTX_O <= 1'b0;
      DESC_RESIDUAL_O <= 16'h0000;
      DESC_STATUS_O <= 16'h0000;
    end else begin
      DESC_UPDATE_O <= finish; // [RQ23]
      if (finish) begin
        DESC_CTX_O <= ctx;
        DESC_RESIDUAL_O <= res[ctx]; // [RQ23]
        DESC_STATUS_O <= is_marker ? {11'h000, EVT_BUS_RESET} : xfer_status;
      end
    end
  end

  // Event pulses; the reset event does not wait for the marker
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RESET_SEEN_EVENT_O <= 1'b0;
      REQUEST_PACKET_EVENT_O <= 1'b0;
      RESPONSE_PACKET_EVENT_O <= 1'b0;
      REQUEST_BUFFER_DONE_EVENT_O <= 1'b0;
      RESPONSE_BUFFER_DONE_EVENT_O <= 1'b0;
    end else begin
      RESET_SEEN_EVENT_O <= br_rise; // [RQ11]
      REQUEST_PACKET_EVENT_O <= finish && ctx == CTX_REQ; // [RQ15]
      RESPONSE_PACKET_EVENT_O <= finish && ctx == CTX_RSP; // [RQ15]
      // A buffer counts as complete once it cannot take another packet
      REQUEST_BUFFER_DONE_EVENT_O <= finish && ctx == CTX_REQ &&
        res[CTX_REQ] < MIN_SPACE && int_sel[CTX_REQ] == INT_ON_DONE; // [RQ16]
      RESPONSE_BUFFER_DONE_EVENT_O <= finish && ctx == CTX_RSP &&
        res[CTX_RSP] < MIN_SPACE && int_sel[CTX_RSP] == INT_ON_DONE; // [RQ16]
    end
  end
endmodule

/* File: pkg/arw_pkg.sv */
package arw_pkg;
  // Quadlet geometry
  localparam int QUAD_W = 32;
  localparam int ADDR_W = 32;
  localparam int COUNT_W = 16;
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
  localparam logic [15:0] QUAD_BYTES = 16'h0004;
  // Room for one more data quadlet, the trailer and a spare
  localparam logic [15:0] MIN_SPACE = 16'h000c;
  // Context selectors
  localparam logic CTX_REQ = 1'b0;
  localparam logic CTX_RSP = 1'b1;
  localparam int NUM_CTX = 2;
  // Transaction code position in the first header quadlet
  localparam int TCODE_LSB = 4;
  localparam logic [3:0] TCODE_PHY = 4'he;
  localparam logic [3:0] TCODE_WR_RSP = 4'h2;
  localparam logic [3:0] TCODE_RDQ_RSP = 4'h6;
  localparam logic [3:0] TCODE_RDB_RSP = 4'h7;
  localparam logic [3:0] TCODE_LOCK_RSP = 4'hb;
  // Bus-reset marker fields
  localparam logic [4:0] EVT_BUS_RESET = 5'h09;
  localparam logic [7:0] MARK_UNDEF = 8'h00;
  localparam int GEN_LSB = 16;
  // Descriptor interrupt field value that asks for a buffer-done event
  localparam logic [1:0] INT_ON_DONE = 2'b11;
  // Cycle timer layout: seconds above count above offset
  localparam int CT_SEC_LSB = 25;
  localparam int CT_CNT_LSB = 12;
  localparam int SEC_BITS = 3;
  localparam int CNT_BITS = 13;
  localparam int STATUS_BITS = 16;
  // Writer sequence
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HOLD = 3'b001,
    ST_PHY0 = 3'b010,
    ST_FLUSH = 3'b011,
    ST_STREAM = 3'b100,
    ST_MARK = 3'b101,
    ST_TRAIL = 3'b110,
    ST_DONE = 3'b111
  } arw_state_e;
endpackage

/* File: rtl/arw_sync.sv */
`timescale 1ns/10ps
module arw_sync (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic async_i,
  output logic rise_o
);
  logic meta; // First stage, read only by the second
  logic stable; // Second stage, safe for logic
  logic stable_d; // Delayed copy for edge finding

  // Two-flop synchroniser followed by a rising-edge detector
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= 1'b0;
      stable <= 1'b0;
      stable_d <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      meta <= async_i;
      stable <= meta;
      stable_d <= stable;
      rise_o <= stable & ~stable_d;
    end
  end
endmodule

/* File: rtl/arw_stamp.sv */
`timescale 1ns/10ps
module arw_stamp
  import arw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic cycle_start_i,
  input wire logic [31:0] cycle_start_time_i,
  input wire logic master_present_i,
  input wire logic [31:0] cycle_time_reg_i,
  output logic [15:0] stamp_o
);
  logic [15:0] last_start; // Stamp from the latest cycle start seen

  // Keep seconds[2:0] and the count of the most recent cycle start
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      last_start <= 16'h0000;
    end else if (cycle_start_i) begin
      last_start <= {cycle_start_time_i[CT_SEC_LSB +: SEC_BITS],
                     cycle_start_time_i[CT_CNT_LSB +: CNT_BITS]}; // [RQ2] [RQ3]
    end
  end

  // Without a cycle master fall back to the local timer
  always_comb begin
    if (master_present_i) begin
      stamp_o = last_start; // [RQ3]
    end else begin
      stamp_o = {cycle_time_reg_i[CT_SEC_LSB +: SEC_BITS],
                 cycle_time_reg_i[CT_CNT_LSB +: CNT_BITS]}; // [RQ3]
    end
  end
endmodule

/* File: test/arw_mem_model.sv */
`timescale 1ns/10ps
// Host memory side: takes writes at once, or stalls most cycles when slow
module arw_mem_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic slow_i,
  output logic ready_o
);
  logic [2:0] cnt; // Stall pattern phase
  // Slow mode accepts one cycle in eight, so writes must stand for a while
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 3'h0;
      ready_o <= 1'b0;
    end else begin
      cnt <= cnt + 3'h1;
      ready_o <= !slow_i || (cnt == 3'h5);
    end
  end
endmodule

/* File: test/arw_writer_assertions.sv */
`timescale 1ns/10ps
module arw_writer_assertions
  import arw_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  input wire logic [31:0] RX_DATA_I,
  input wire logic RX_VALID_I,
  input wire logic RX_CRC_I,
  input wire logic RX_READY_O,
  input wire logic BUS_RESET_I,
  input wire logic [1:0] BUF_LOAD_I,
  input wire logic [1:0] BUF_INT_I,
  input wire logic MEM_READY_I,
  input wire logic MEM_WE_O,
  input wire logic [31:0] MEM_ADDR_O,
  input wire logic [31:0] MEM_DATA_O,
  input wire logic DESC_UPDATE_O,
  input wire logic DESC_CTX_O,
  input wire logic [15:0] DESC_RESIDUAL_O,
  input wire logic RESET_SEEN_EVENT_O,
  input wire logic REQUEST_PACKET_EVENT_O,
  input wire logic RESPONSE_PACKET_EVENT_O,
  input wire logic REQUEST_BUFFER_DONE_EVENT_O,
  input wire logic RESPONSE_BUFFER_DONE_EVENT_O
);
  logic [1:0] req_int; // Interrupt field of the loaded request buffer
  logic [1:0] rsp_int; // Interrupt field of the loaded response buffer
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  // Remember what each buffer asked for at load time
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      req_int <= 2'b00;
      rsp_int <= 2'b00;
    end else begin
      if (BUF_LOAD_I[0]) begin
        req_int <= BUF_INT_I;
      end
      if (BUF_LOAD_I[1]) begin
        rsp_int <= BUF_INT_I;
      end
    end
  end
  AST_WE_HOLD:
    assert property (MEM_WE_O && !MEM_READY_I |=> MEM_WE_O && $stable(MEM_ADDR_O)
      && $stable(MEM_DATA_O)) else $error("Write changed before taken");
  AST_READY_LOW:
    assert property (MEM_WE_O |-> !RX_READY_O) else $error("Ready while write open");
  AST_NO_CRC:
    assert property (RX_VALID_I && RX_READY_O && RX_CRC_I |=>
      !(MEM_WE_O && MEM_DATA_O == $past(RX_DATA_I))) else $error("CRC quadlet stored");
  AST_RST_EVT:
    assert property ($rose(BUS_RESET_I) |-> ##[2:5] RESET_SEEN_EVENT_O)
      else $error("Reset event late");
  AST_RST_PULSE:
    assert property (RESET_SEEN_EVENT_O |=> !RESET_SEEN_EVENT_O) else $error("Reset event long");
  AST_REQ_EVT:
    assert property (REQUEST_PACKET_EVENT_O == (DESC_UPDATE_O && !DESC_CTX_O))
      else $error("Request event mismatch");
  AST_RSP_EVT:
    assert property (RESPONSE_PACKET_EVENT_O == (DESC_UPDATE_O && DESC_CTX_O))
      else $error("Response event mismatch");
  AST_BUF_DONE:
    assert property (DESC_UPDATE_O && !DESC_CTX_O && DESC_RESIDUAL_O < MIN_SPACE
      && req_int == INT_ON_DONE |-> ##[0:1] REQUEST_BUFFER_DONE_EVENT_O)
      else $error("Buffer done event missing");
  AST_BUF_QUIET:
    assert property (REQUEST_BUFFER_DONE_EVENT_O |-> req_int == INT_ON_DONE)
      else $error("Buffer done event unasked");
  AST_RSP_DONE:
    assert property (DESC_UPDATE_O && DESC_CTX_O && DESC_RESIDUAL_O < MIN_SPACE
      && rsp_int == INT_ON_DONE |-> RESPONSE_BUFFER_DONE_EVENT_O)
      else $error("Response buffer done event missing");
  AST_RSP_QUIET:
    assert property (RESPONSE_BUFFER_DONE_EVENT_O |-> DESC_UPDATE_O && DESC_CTX_O
      && rsp_int == INT_ON_DONE) else $error("Response buffer done event unasked");
  AST_UPD_PULSE:
    assert property (DESC_UPDATE_O |=> !DESC_UPDATE_O) else $error("Update pulse long");
endmodule
bind arw_writer arw_writer_assertions chk (
  .CORE_CLK_I, .RSTN_I, .RX_DATA_I, .RX_VALID_I, .RX_CRC_I, .RX_READY_O, .BUS_RESET_I,
  .BUF_LOAD_I, .BUF_INT_I, .MEM_READY_I, .MEM_WE_O, .MEM_ADDR_O, .MEM_DATA_O,
  .DESC_UPDATE_O, .DESC_CTX_O, .DESC_RESIDUAL_O, .RESET_SEEN_EVENT_O,
  .REQUEST_PACKET_EVENT_O, .RESPONSE_PACKET_EVENT_O, .REQUEST_BUFFER_DONE_EVENT_O,
  .RESPONSE_BUFFER_DONE_EVENT_O
);

/* File: test/arw_writer_tb_top.sv */
`timescale 1ns/10ps
module arw_writer_tb_top;
  import arw_pkg::*;
  logic [15:0] cc_req, cc_rsp; // Context control low halves, random so the trailer must track them
  logic clk, rstn, vld, last, crc, bad, derr, brst, acc, cst, mst, slow, skip;
  logic [31:0] dat, cst_t, ctr, badr, seed, wa;
  logic [15:0] bsz;
  logic [7:0] gen;
  logic [1:0] ld, bint;
  logic rdy, mrdy, we, upd, dctx;
  logic [31:0] addr, wdat;
  logic [15:0] resid, dstat;
  logic [95:0] wq[$]; // Expected writes {addr, data, mask}
  logic [32:0] dq[$]; // Expected updates {ctx, residual, status}
  logic [31:0] ptr[2]; // Next write address per context
  logic [15:0] res[2]; // Residual per context
  int n_mismatch, check_count, cyc, i;
  arw_writer dut (
    .CORE_CLK_I(clk), .RSTN_I(rstn), .RX_DATA_I(dat), .RX_VALID_I(vld), .RX_LAST_I(last),
    .RX_CRC_I(crc), .RX_CRC_BAD_I(bad), .RX_DATA_ERR_I(derr), .RX_READY_O(rdy),
    .BUS_RESET_I(brst), .TOPOLOGY_GENERATION_I(gen), .ACCEPT_PHY_PACKETS_I(acc),
    .CONTEXT_CONTROL_REQ_I(cc_req), .CONTEXT_CONTROL_RSP_I(cc_rsp), .CYCLE_START_I(cst),
    .CYCLE_START_TIME_I(cst_t), .CYCLE_MASTER_PRESENT_I(mst), .CYCLE_TIME_REG_I(ctr),
    .BUF_LOAD_I(ld), .BUF_ADDR_I(badr), .BUF_SIZE_I(bsz), .BUF_INT_I(bint),
    .MEM_READY_I(mrdy), .MEM_WE_O(we), .MEM_ADDR_O(addr), .MEM_DATA_O(wdat),
    .DESC_UPDATE_O(upd), .DESC_CTX_O(dctx), .DESC_RESIDUAL_O(resid), .DESC_STATUS_O(dstat),
    .RESET_SEEN_EVENT_O(), .REQUEST_PACKET_EVENT_O(), .RESPONSE_PACKET_EVENT_O(),
    .REQUEST_BUFFER_DONE_EVENT_O(), .RESPONSE_BUFFER_DONE_EVENT_O()
  );
  arw_mem_model mem (.clk_i(clk), .rstn_i(rstn), .slow_i(slow), .ready_o(mrdy));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Repeatable pseudo-random source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Stamp seen by the writer: cycle start time when a master exists
  function automatic logic [15:0] stamp();
    return mst ? {cst_t[27:25], cst_t[24:12]} : {ctr[27:25], ctr[24:12]};
  endfunction
  // Note one expected write at the running address
  task automatic ew(input logic [31:0] d, input logic [31:0] m);
    wq.push_back({wa, d, m});
    wa = wa + 32'h4;
  endtask
  task automatic cmp_w(input logic [95:0] e, input logic [63:0] g);
    check_count++;
    if (((g ^ e[95:32]) & {32'hffff_ffff, e[31:0]}) !== 64'h0) begin
      n_mismatch++;
      $display("Error t=%0t exp=%h got=%h", $time, e[95:32], g);
    end
  endtask
  task automatic cmp_d(input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // Offer one quadlet and hold it until taken; valid stays up for the next
  task automatic put(input logic [31:0] d, input logic [3:0] f);
    dat <= d;
    {last, crc, bad, derr} <= f;
    vld <= 1'b1;
    @(posedge clk);
    while (!rdy) @(posedge clk);
  endtask
  task automatic load(input int c, input logic [15:0] s, input logic [1:0] n);
    ptr[c] = 32'h0001_0000 << c;
    res[c] = s;
    badr <= ptr[c];
    bsz <= s;
    bint <= n;
    ld <= 2'b01 << c;
    @(posedge clk);
    ld <= 2'b00;
    @(posedge clk);
  endtask
  // Modes: 0 normal, 1 PHY accepted, 2 PHY refused, 3 data error
  task automatic send(input logic [3:0] tc, input int nd, input int md);
    logic [31:0] q;
    logic c;
    int k, n;
    n = (md == 1 || md == 2) ? 2 : 4;
    c = (n == 4) && (tc inside {TCODE_WR_RSP, TCODE_RDQ_RSP, TCODE_RDB_RSP, TCODE_LOCK_RSP});
    wa = ptr[c];
    acc <= (md == 1);
    skip <= (md == 3);
    if (md == 1) ew({24'h0, TCODE_PHY, 4'h0}, 32'h0000_00f0);
    for (k = 0; k < n; k++) begin
      q = rnd();
      q[7:4] = (k == 0 && n == 4) ? tc : q[7:4];
      if (md < 2) ew(q, 32'hffff_ffff);
      put(q, {n == 2 && k == 1, 1'b0, n == 2 && k == 1, 1'b0});
    end
    if (n == 4) put(rnd(), {nd == 0, 3'b100});
    for (k = 0; k < nd; k++) begin
      q = rnd();
      if (md < 2) ew(q, 32'hffff_ffff);
      put(q, 4'b0000); // Sender pads to whole quadlets
    end
    if (nd > 0) put(rnd(), {3'b110, md == 3});
    vld <= 1'b0;
    if (md < 2) begin
      ew({c ? cc_rsp : cc_req, stamp()}, 32'hffff_ffff);
      dq.push_back({c, res[c] - 16'(wa - ptr[c]), c ? cc_rsp : cc_req});
      res[c] = res[c] - 16'(wa - ptr[c]);
      ptr[c] = wa;
    end
  endtask
  task automatic breset();
    logic [31:0] r;
    r = rnd();
    gen <= r[7:0];
    wa = ptr[0];
    ew({24'h0, TCODE_PHY, 4'h0}, 32'hffff_ffff);
    ew({MARK_UNDEF, r[7:0], 16'h0}, 32'h00ff_ffff);
    ew({11'h0, EVT_BUS_RESET, stamp()}, 32'hffff_ffff);
    dq.push_back({1'b0, res[0] - 16'h000c, 11'h0, EVT_BUS_RESET});
    res[0] = res[0] - 16'h000c;
    ptr[0] = wa;
    @(posedge clk);
    brst <= 1'b1;
    repeat (3) @(posedge clk);
    brst <= 1'b0;
  endtask
  // Wait until every noted result has appeared, bounded
  task automatic drain();
    int t;
    t = 0;
    while ((wq.size() != 0 || dq.size() != 0 || t < 8) && t < 400) begin
      t++;
      @(posedge clk);
    end
    skip <= 1'b0;
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watcher: each taken write while skip is clear, and each update, meets the oldest note
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rstn && we && mrdy && !skip) begin
      cmp_w(wq.size() != 0 ? wq.pop_front() : 'x, {addr, wdat});
    end
    if (rstn && upd) begin
      cmp_d(dq.size() != 0 ? dq.pop_front() : 'x, {dctx, resid, dstat});
    end
    // Ceiling on run length; a hang ends here as a failure
    if (cyc == 30000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    {rstn, vld, last, crc, bad, derr, brst, acc, cst, mst, slow, skip} = '0;
    {dat, cst_t, badr, bsz, gen, ld, bint} = '0;
    seed = 32'd82178;
    ctr = rnd();
    {cc_req, cc_rsp} = rnd();
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    load(0, 16'h0400, 2'b00);
    load(1, 16'h0400, 2'b00);
    send(4'h0, 0, 0);
    drain();
    slow <= 1'b1;
    send(4'h7, 2, 0);
    drain();
    slow <= 1'b0;
    send(4'h0, 0, 1);
    drain();
    send(4'h0, 0, 2);
    drain();
    send(4'h1, 2, 3);
    drain();
    breset();
    drain();
    load(0, 16'h001c, INT_ON_DONE);
    send(4'h0, 0, 0); // Leaves the buffer nearly full
    drain();
    load(1, 16'h001c, INT_ON_DONE);
    send(4'h2, 0, 0); // Response buffer nearly full as well
    drain();
    load(0, 16'hf000, 2'b00);
    load(1, 16'hf000, 2'b00);
    mst <= 1'b1;
    cst_t <= rnd();
    {cc_req, cc_rsp} <= rnd();
    cst <= 1'b1;
    @(posedge clk);
    cst <= 1'b0;
    repeat (3) @(posedge clk);
    for (i = 0; i < 16; i++) begin
      slow <= i[0];
      send(4'(i), i % 3, 0);
      drain();
    end
    while (wq.size() != 0) cmp_w(wq.pop_front(), 'x);
    while (dq.size() != 0) cmp_d(dq.pop_front(), 'x);
    close_out();
  end
endmodule
